// ---- iopb_top.sv ----
`timescale 1ns/1ps
`include "iopb_regs.svh"
// ----------------------------------------
// What this block does
// - 57 lines: seven byte ports, one bit
// - each bit except port6: latch, driver, input buffer
// - each port accessed through own register
// - port5 quasi when mode bit clear
// - reset selects quasi structure for port5
// - bidirectional: per-pin direction from register
// - direction shares port5 data address
// - direction reached when map bit set; resets FF
// - port0 multiplexes low address then data
// - port2 drives high address or latch
// - port6 input only, read returns pins
// - writes to port6 register ignored
// - three-bit field selects analog channel
// - port6 byte read samples all together
// ----------------------------------------
module iopb_top (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       ce,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   output logic            sfr_rvalid,
   input  wire logic       xm_start,
   input  wire logic       xm_wide,
   input  wire logic       xm_write,
   input  wire logic [15:0] xm_addr,
   input  wire logic [7:0] xm_wdata,
   output logic      [7:0] xm_rdata,
   input  wire logic [7:0] p0_in,
   output logic      [7:0] p0_out,
   output logic      [7:0] p0_oe,
   input  wire logic [7:0] p1_in,
   output logic      [7:0] p1_out,
   output logic      [7:0] p1_oe,
   input  wire logic [7:0] p2_in,
   output logic      [7:0] p2_out,
   output logic      [7:0] p2_oe,
   input  wire logic [7:0] p3_in,
   output logic      [7:0] p3_out,
   output logic      [7:0] p3_oe,
   input  wire logic [7:0] p4_in,
   output logic      [7:0] p4_out,
   output logic      [7:0] p4_oe,
   input  wire logic [7:0] p5_in,
   output logic      [7:0] p5_out,
   output logic      [7:0] p5_oe,
   output logic      [7:0] p5_weak,
   input  wire logic [7:0] p6_in,
   input  wire logic       p7_in,
   output logic            p7_out,
   output logic            p7_oe,
   output logic      [2:0] an_chan
);
   iopb_pkg::iopb_state_t s_q;
   iopb_pkg::iopb_state_t s_d;
   logic [63:0]           pin_sync;
   logic                  port5_structure_select;
   logic                  direction_map_select;

   // ----------------------------------------
   // pin input synchronisers
   // ----------------------------------------
   iopb_pin_sync u_sync (
      .clk      (clk),
      .srst     (srst),
      .ce       (ce),
      .pin_in   ({7'h00, p7_in, p6_in, p5_in, p4_in,
                  p3_in, p2_in, p1_in, p0_in}),
      .pin_sync (pin_sync)
   );

   assign port5_structure_select = s_q.sysctl[`IOPB_SYSCTL_PORT5_STRUCTURE_SELECT_BIT];
   assign direction_map_select = s_q.priob[`IOPB_PRIOB_DIRECTION_MAP_SELECT_BIT];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d        = s_q;
      s_d.rvalid = 1'h0;
      s_d.pin_q1 = '0;
      s_d.pin_q2 = '0;
      s_d.p134_dummy = 8'h00;
      // register writes
      if (sfr_wr) begin
         unique case (sfr_addr)
            `IOPB_ADDR_P0:     s_d.latch[0] = sfr_wdata;
            `IOPB_ADDR_P1:     s_d.latch[1] = sfr_wdata;
            `IOPB_ADDR_P2:     s_d.latch[2] = sfr_wdata;
            `IOPB_ADDR_P3:     s_d.latch[3] = sfr_wdata;
            `IOPB_ADDR_P4:     s_d.latch[4] = sfr_wdata;
            `IOPB_ADDR_P5: begin
               if (direction_map_select) begin
                  s_d.port5_direction = sfr_wdata;
               end else begin
                  s_d.latch[5] = sfr_wdata;
               end
            end
            `IOPB_ADDR_P7:     s_d.p7_latch = sfr_wdata[0];
            `IOPB_ADDR_SYSCTL: s_d.sysctl = sfr_wdata;
            `IOPB_ADDR_PRIOB:  s_d.priob = sfr_wdata;
            `IOPB_ADDR_CONVA:  s_d.conva = sfr_wdata;
            `IOPB_ADDR_CONVB:  s_d.convb = sfr_wdata;
            `IOPB_ADDR_P6: ; // no effect
            default: ;
         endcase
      end
      // register reads: ports return synchronised pin levels, port5 the direction register when the map bit is set
      if (sfr_rd) begin
         s_d.rvalid = 1'h1;
         unique case (sfr_addr)
            `IOPB_ADDR_P0:     s_d.rdata = pin_sync[7:0];
            `IOPB_ADDR_P1:     s_d.rdata = pin_sync[15:8];
            `IOPB_ADDR_P2:     s_d.rdata = pin_sync[23:16];
            `IOPB_ADDR_P3:     s_d.rdata = pin_sync[31:24];
            `IOPB_ADDR_P4:     s_d.rdata = pin_sync[39:32];
            `IOPB_ADDR_P5:     s_d.rdata = direction_map_select ? s_q.port5_direction
                                                : pin_sync[47:40];
            `IOPB_ADDR_P6:     s_d.rdata = pin_sync[55:48];
            `IOPB_ADDR_P7:     s_d.rdata = {7'h00, pin_sync[56]};
            `IOPB_ADDR_SYSCTL: s_d.rdata = s_q.sysctl;
            `IOPB_ADDR_PRIOB:  s_d.rdata = s_q.priob;
            `IOPB_ADDR_CONVA:  s_d.rdata = s_q.conva;
            `IOPB_ADDR_CONVB:  s_d.rdata = s_q.convb;
            default:           s_d.rdata = 8'h00;
         endcase
      end
      // analog channel select: conva or convb field
      s_d.an_chan = s_d.conva[`IOPB_CONVA_ADM_BIT]
                  ? s_d.convb[`IOPB_CONV_MX_LSB +: 3]
                  : s_d.conva[`IOPB_CONV_MX_LSB +: 3];
      // external memory sequencer
      unique case (s_q.xm)
         iopb_pkg::IOPB_XM_IDLE: begin
            if (xm_start) begin
               s_d.xm = iopb_pkg::IOPB_XM_ADDR;
            end
         end
         iopb_pkg::IOPB_XM_ADDR: s_d.xm = iopb_pkg::IOPB_XM_DATA;
         iopb_pkg::IOPB_XM_DATA: s_d.xm = iopb_pkg::IOPB_XM_IDLE;
         default:                s_d.xm = iopb_pkg::IOPB_XM_IDLE;
      endcase
      // read data phase: capture pins after the two sync stages
      s_d.xrd_pipe = {s_q.xrd_pipe[0],
                      s_q.xm == iopb_pkg::IOPB_XM_DATA && !xm_write};
      if (s_q.xrd_pipe[1]) begin
         s_d.xrdata = pin_sync[7:0];
      end
      // port0: address, then data; else latch open-drain style
      if (s_d.xm == iopb_pkg::IOPB_XM_ADDR) begin
         s_d.p0_out = xm_addr[7:0];
         s_d.p0_oe  = 8'hFF;
      end else if (s_d.xm == iopb_pkg::IOPB_XM_DATA) begin
         s_d.p0_out = xm_wdata;
         s_d.p0_oe  = xm_write ? 8'hFF : 8'h00;
      end else begin
         s_d.p0_out = s_d.latch[0];
         s_d.p0_oe  = ~s_d.latch[0];
      end
      // port2: high address during wide access, else latch
      if (s_d.xm != iopb_pkg::IOPB_XM_IDLE && xm_wide) begin
         s_d.p2_out = xm_addr[15:8];
      end else begin
         s_d.p2_out = s_d.latch[2];
      end
      // port5 structure
      if (s_d.sysctl[`IOPB_SYSCTL_PORT5_STRUCTURE_SELECT_BIT]) begin
         s_d.p5_out  = s_d.latch[5];
         s_d.p5_oe   = ~s_d.port5_direction;
         s_d.p5_weak = 8'h00;
      end else begin
         s_d.p5_out  = s_d.latch[5];
         s_d.p5_oe   = ~s_d.latch[5];
         s_d.p5_weak = s_d.latch[5];
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         s_q          <= '0;
         s_q.latch    <= {6{`IOPB_PORT_RST}};
         s_q.p7_latch <= `IOPB_P7_RST;
         s_q.port5_direction     <= `IOPB_PORT5_DIRECTION_RST;
         s_q.sysctl   <= `IOPB_SYSCTL_RST;
         s_q.priob    <= `IOPB_PRIOB_RST;
         s_q.conva    <= `IOPB_CONV_RST;
         s_q.convb    <= `IOPB_CONV_RST;
         s_q.p0_out   <= `IOPB_PORT_RST;
         s_q.p2_out   <= `IOPB_PORT_RST;
         s_q.p5_out   <= `IOPB_PORT_RST;
         s_q.p5_weak  <= `IOPB_PORT_RST;
         s_q.xm       <= iopb_pkg::IOPB_XM_IDLE;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs (quasi ports: drive low for 0)
   // ----------------------------------------
   assign sfr_rdata  = s_q.rdata;
   assign sfr_rvalid = s_q.rvalid;
   assign xm_rdata   = s_q.xrdata;
   assign p0_out     = s_q.p0_out;
   assign p0_oe      = s_q.p0_oe;
   assign p1_out     = s_q.latch[1];
   assign p1_oe      = ~s_q.latch[1];
   assign p2_out     = s_q.p2_out;
   assign p2_oe      = 8'hFF;
   assign p3_out     = s_q.latch[3];
   assign p3_oe      = ~s_q.latch[3];
   assign p4_out     = s_q.latch[4];
   assign p4_oe      = ~s_q.latch[4];
   assign p5_out     = s_q.p5_out;
   assign p5_oe      = s_q.p5_oe;
   assign p5_weak    = s_q.p5_weak;
   assign p7_out     = s_q.p7_latch;
   assign p7_oe      = ~s_q.p7_latch;
   assign an_chan    = s_q.an_chan;
endmodule

// ---- iopb_regs.svh ----
`ifndef IOPB_REGS_SVH
`define IOPB_REGS_SVH
// ----------------------------------------
// register addresses (special function space)
// ----------------------------------------
`define IOPB_ADDR_P0     8'h80
`define IOPB_ADDR_P1     8'h90
`define IOPB_ADDR_P2     8'hA0
`define IOPB_ADDR_P3     8'hB0
`define IOPB_ADDR_SYSCTL 8'hB1
`define IOPB_ADDR_PRIOB  8'hB9
`define IOPB_ADDR_CONVA  8'hD8
`define IOPB_ADDR_P6     8'hDB
`define IOPB_ADDR_CONVB  8'hDC
`define IOPB_ADDR_P4     8'hE8
`define IOPB_ADDR_P5     8'hF8
`define IOPB_ADDR_P7     8'hFA
// ----------------------------------------
// field positions
// ----------------------------------------
`define IOPB_SYSCTL_PORT5_STRUCTURE_SELECT_BIT 6
`define IOPB_PRIOB_DIRECTION_MAP_SELECT_BIT  7
`define IOPB_CONV_MX_LSB     0
`define IOPB_CONVA_ADM_BIT   3
// ----------------------------------------
// reset values
// ----------------------------------------
`define IOPB_PORT_RST    8'hFF
`define IOPB_PORT5_DIRECTION_RST    8'hFF
`define IOPB_P7_RST      1'h1
`define IOPB_SYSCTL_RST  8'h21
`define IOPB_PRIOB_RST   8'h00
`define IOPB_CONV_RST    8'h00
`endif

// ---- iopb_pkg.sv ----
package iopb_pkg;
   typedef enum logic [1:0] {
      IOPB_XM_IDLE = 2'b00,
      IOPB_XM_ADDR = 2'b01,
      IOPB_XM_DATA = 2'b10
   } iopb_xm_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic       wr_seen;
   } iopb_bank_t;

   typedef struct packed {
      logic [5:0][7:0] latch;
      logic            p7_latch;
      logic [7:0]      port5_direction;
      logic [7:0]      sysctl;
      logic [7:0]      priob;
      logic [7:0]      conva;
      logic [7:0]      convb;
      logic [6:0][7:0] pin_q1;
      logic [6:0][7:0] pin_q2;
      logic [7:0]      rdata;
      logic            rvalid;
      logic [7:0]      p0_out;
      logic [7:0]      p0_oe;
      logic [7:0]      p2_out;
      logic [7:0]      p5_out;
      logic [7:0]      p5_oe;
      logic [7:0]      p5_weak;
      logic [7:0]      p134_dummy;
      logic [2:0]      an_chan;
      logic [1:0]      xrd_pipe;
      logic [7:0]      xrdata;
      iopb_xm_t        xm;
   } iopb_state_t;
endpackage

// ---- iopb_pin_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser bank, one per pin line
module iopb_pin_sync (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic [63:0] pin_in,
   output logic      [63:0] pin_sync
);
   logic [63:0] s1_q;
   logic [63:0] s2_q;

   genvar g;
   generate
      for (g = 0; g < 64; g++) begin : g_bit
         always_ff @(posedge clk) begin
            if (srst) begin
               s1_q[g] <= 1'h1;
               s2_q[g] <= 1'h1;
            end else if (ce) begin
               s1_q[g] <= pin_in[g];
               s2_q[g] <= s1_q[g];
            end
         end
      end
   endgenerate

   assign pin_sync = s2_q;
endmodule

// ---- iopb_checker.sv ----
`timescale 1ns/1ps
// ------------------------------------
// port behaviour checks
// ------------------------------------
module iopb_checker (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        ce,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_wr,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_wdata,
   input wire logic        sfr_rvalid,
   input wire logic        xm_start,
   input wire logic        xm_wide,
   input wire logic        xm_write,
   input wire logic [15:0] xm_addr,
   input wire logic [7:0]  xm_wdata,
   input wire logic [7:0]  p0_out,
   input wire logic [7:0]  p0_oe,
   input wire logic [7:0]  p1_out,
   input wire logic [7:0]  p2_out,
   input wire logic [7:0]  p2_oe,
   input wire logic [7:0]  p5_out,
   input wire logic [7:0]  p5_weak,
   input wire logic [2:0]  an_chan
);
   logic direction_map_select_q;
   always_ff @(posedge clk) begin
      if (srst) begin
         direction_map_select_q <= 1'b0;
      end else if (ce && sfr_wr && sfr_addr == 8'hB9) begin
         direction_map_select_q <= sfr_wdata[7];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_wr(a); ce && sfr_wr && sfr_addr == a; endsequence
   sequence s_xm; ce && xm_start; endsequence
   property p_rvalid; ce && sfr_rd |=> sfr_rvalid; endproperty
   a_rvalid: assert property (p_rvalid)
      else $error("read valid missing");
   property p_p1; s_wr(8'h90) |=> p1_out == $past(sfr_wdata); endproperty
   a_p1: assert property (p_p1)
      else $error("port1 write lost");
   property p_p5;
      s_wr(8'hF8) ##0 !direction_map_select_q |=> p5_out == $past(sfr_wdata);
   endproperty
   a_p5: assert property (p_p5)
      else $error("port5 write lost");
   property p_dir; s_wr(8'hF8) ##0 direction_map_select_q |=> $stable(p5_out); endproperty
   a_dir: assert property (p_dir)
      else $error("direction write hit latch");
   property p_xm;
      s_xm ##0 xm_wide |=> p2_out == $past(xm_addr[15:8])
         && p0_out == $past(xm_addr[7:0]);
   endproperty
   a_xm: assert property (p_xm)
      else $error("address phase wrong");
   property p_xmw;
      s_xm ##0 xm_write |=> ##1 p0_oe == 8'hFF && p0_out == $past(xm_wdata, 2);
   endproperty
   a_xmw: assert property (p_xmw)
      else $error("data phase wrong");
   property p_ro;
      s_wr(8'hDB) |=> $stable(p1_out) && $stable(p5_out) && $stable(an_chan);
   endproperty
   a_ro: assert property (p_ro)
      else $error("port6 write had effect");
   property p_an;
      s_wr(8'hD8) ##0 !sfr_wdata[3]
         |=> {5'h00, an_chan} == ($past(sfr_wdata) & 8'h07);
   endproperty
   a_an: assert property (p_an)
      else $error("channel select wrong");
   property p_rst;
      $fell(srst) |-> p5_weak == 8'hFF && p5_out == 8'hFF && p2_oe == 8'hFF;
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset state wrong");
endmodule

bind iopb_top iopb_checker u_chk (.*);

// ---- iopb_partner.sv ----
`timescale 1ns/1ps
// ------------------------------------
// external memory and port5 sources
// ------------------------------------
module iopb_partner (
   input  wire logic       clk,
   input  wire logic [7:0] p0_out,
   input  wire logic [7:0] p0_oe,
   input  wire logic [7:0] p5_out,
   input  wire logic [7:0] p5_oe,
   input  wire logic [7:0] p5_weak,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] p0_in,
   output logic      [7:0] p5_in
);
   logic [7:0] addr_q;
   logic [7:0] last_q;
   always_ff @(posedge clk) begin
      if (p0_oe == 8'hFF) begin
         addr_q <= p0_out;
      end
      last_q <= p5_in;
   end
   // memory answers inverted low address
   assign p0_in = (p0_oe == 8'hFF) ? p0_out : ~addr_q;
   // undriven lines pull high where weak is set, else drift to inverse
   assign p5_in = (p5_oe & p5_out) | (~p5_oe & ext_en & ext_val)
      | (~p5_oe & ~ext_en & (p5_weak | ~last_q));
endmodule

// ---- io_port_block_test.sv ----
`timescale 1ns/1ps
// ------------------------------------
// self-checking bench
// ------------------------------------
module io_port_block_test;
   logic        clk, srst, ce, sfr_wr, sfr_rd, sfr_rvalid;
   logic        xm_start, xm_wide, xm_write, p7_out, p7_oe;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xm_wdata, xm_rdata;
   logic [7:0]  ext_en, ext_val, p6_in, rv, p0_in, p0_out, p0_oe;
   logic [7:0]  p1_out, p1_oe, p2_out, p2_oe, p3_out, p3_oe, p4_out;
   logic [7:0]  p4_oe, p5_in, p5_out, p5_oe, p5_weak;
   logic [15:0] xm_addr;
   logic [2:0]  an_chan;
   logic [31:0] seed;
   int          err_total, samples_checked;
   wire  [7:0]  p1_in = p1_out;
   wire  [7:0]  p2_in = p2_out;
   wire  [7:0]  p3_in = p3_out;
   wire  [7:0]  p4_in = p4_out;
   wire         p7_in = p7_out;
   iopb_top dut (.*);
   iopb_partner u_far (.*);
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] pin5(input logic [7:0] dir, l, e);
      return (l & ~dir) | (e & dir);
   endfunction
   task give_verdict;
      if (err_total == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input logic [7:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [7:0] a, d);
      wt(1);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1;
      wt(1);
      sfr_wr = 0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      wt(1);
      sfr_addr = a;
      sfr_rd = 1;
      wt(1);
      sfr_rd = 0;
      d = sfr_rdata;
   endtask
   task xm(input logic [15:0] a, input logic w, wr_, input logic [7:0] d);
      wt(1);
      {xm_addr, xm_wide, xm_write, xm_wdata, xm_start} = {a, w, wr_, d, 1'b1};
      wt(1);
      xm_start = 0;
      chk(p0_out, a[7:0]);
      chk(p2_out, w ? a[15:8] : 8'h3C);
      wt(1);
      chk(p0_oe, wr_ ? 8'hFF : 8'h00);
      if (wr_) chk(p0_out, d);
      wt(3);
   endtask
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      give_verdict;
   end
   initial begin
      {srst, ce, sfr_wr, sfr_rd, xm_start, xm_wide, xm_write} = 7'h60;
      {sfr_addr, sfr_wdata, xm_wdata, ext_en, ext_val, p6_in} = '0;
      {xm_addr, err_total, samples_checked} = '0;
      seed = 32'hAD8C;
      wt(6);
      srst = 0;
      chk(p5_weak, 8'hFF);
      repeat (20) begin
         seed = nxt(seed);
         wr(8'h90, seed[7:0]);
         wr(8'hE8, seed[23:16]);
         wr(8'hB0, seed[15:8]);
         p6_in = seed[31:24];
         wt(4);
         rd(8'h90, rv);
         chk(rv, seed[7:0]);
         rd(8'hE8, rv);
         chk(rv, seed[23:16]);
         chk(p3_out, seed[15:8]);
         wr(8'hDB, ~seed[31:24]);
         rd(8'hDB, rv);
         chk(rv, seed[31:24]);
      end
      rd(8'h81, rv);
      chk(rv, 8'h00);
      wr(8'hFA, 8'h00);
      wt(4);
      rd(8'hFA, rv);
      chk(rv, 8'h00);
      ce = 0;
      wr(8'h90, ~seed[7:0]);
      ce = 1;
      chk(p1_out, seed[7:0]);
      for (int m = 0; m < 8; m++) begin
         wr(8'hD8, m[7:0]);
         chk({5'h00, an_chan}, m[7:0]);
      end
      wr(8'hDC, 8'h05);
      wr(8'hD8, 8'h08);
      chk({5'h00, an_chan}, 8'h05);
      {ext_en, ext_val} = 16'hFF5A;
      rd(8'hF8, rv);
      wt(4);
      rd(8'hF8, rv);
      chk(rv, 8'h5A);
      wr(8'hF8, 8'h0F);
      ext_val = 8'hFF;
      wt(4);
      rd(8'hF8, rv);
      chk(rv, 8'h0F);
      wr(8'hB1, 8'h61);
      wr(8'hB9, 8'h80);
      wr(8'hF8, 8'h0F);
      wr(8'hB9, 8'h00);
      wr(8'hF8, 8'hA5);
      {ext_en, ext_val} = 16'h0F3C;
      chk(p5_oe, 8'hF0);
      chk(p5_weak, 8'h00);
      wt(4);
      rd(8'hF8, rv);
      chk(rv, pin5(8'h0F, 8'hA5, 8'h3C));
      wr(8'hA0, 8'h3C);
      repeat (4) begin
         seed = nxt(seed);
         xm(seed[15:0], seed[16], 1'b1, seed[31:24]);
      end
      xm(16'h77E1, 1'b0, 1'b0, 8'h00);
      chk(xm_rdata, 8'h1E);
      give_verdict;
   end
endmodule
